//--- hdl/cpa_adjust_ctrl.sv
// Conversion period adjust control with AXI4-Lite registers and test modes
// What this block does
// - Incremental period adjustment lands near the end of each period.
// - Receive adjust hits current period if time remains, else next.
// - Receive part dropped when receive period already scheduled.
// - Transmit dividers, offset and control always accepted, applied now.
// - Receive values apply this period when time permits, else next.
// - Further receive values ignored while a period already uses some.
// - Test select open means normal; driven to 0 V or 5 V means test.
// - D/A test outputs low-pass clock and D/A start; tx word done kept.
// - A/D test outputs bandpass clock, A/D start, filter; rx done kept.
// - In test mode word/byte select at negative supply acts as byte mode.
// - Either path test may run with the low-pass filter input test.
// - Negative divider A plus offset loads the sum plus 64.
// - Divider A plus or minus offset of 0 or 1 loads plain divider A.
// - Transmit divider B written as 0 or 1 becomes 0x24.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`default_nettype none
module cpa_adjust_ctrl import cpa_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic master_clock_in,
	input wire logic factory_test_select_hi,
	input wire logic factory_test_select_gnd,
	input wire logic word_byte_select_neg,
	input wire logic tx_word_done,
	input wire logic rx_word_done,
	output logic test_filter_clk_q,
	output logic test_pin_tx_q,
	output logic test_pin_rx_q,
	output logic rx_filter_out_en_q,
	output logic lpf_input_test_q,
	output logic byte_mode_q,
	output logic tx_conv_start_q,
	output logic rx_conv_start_q
);
	// ************************************************************
	// Pin synchronisation and master clock edges
	// ************************************************************
	logic [3:0] pins_sync;
	logic mclk_prev_q;
	logic mclk_tick;

	cpa_sync #(.W(4)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin({master_clock_in, factory_test_select_hi,
			factory_test_select_gnd, word_byte_select_neg}),
		.level(pins_sync)
	);

	// Rising master clock edge, found on the settled level
	always_ff @(posedge aclk) begin
		if (!aresetn)
			mclk_prev_q <= 1'b0;
		else
			mclk_prev_q <= pins_sync[3];
	end
	assign mclk_tick = pins_sync[3] & ~mclk_prev_q;

	// ************************************************************
	// Registers
	// ************************************************************
	cpa_period_cfg_s tx_cfg_q;
	cpa_period_cfg_s rx_cfg_q;
	cpa_period_cfg_s rx_stage_q;
	logic [CTRL_W-1:0] control_q;
	logic [1:0] tx_adj_q;
	logic [1:0] rx_adj_q;
	logic [1:0] rx_adj_next_q;
	logic rx_lock_q;
	logic rx_staged_q;

	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************
	logic aw_full_q;
	logic w_full_q;
	logic [5:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic wr_hit;

	assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;

	// Address and data taken in either order, held until both are here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_full_q & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_full_q & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_full_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// Write response one cycle after both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Decode; status is read-only so a write there is refused
	always_comb begin
		case (aw_addr_q)
			OFF_TX_DIV_A, OFF_TX_OFFSET, OFF_TX_DIV_B,
			OFF_RX_DIV_A, OFF_RX_OFFSET, OFF_RX_DIV_B,
			OFF_CONTROL, OFF_ADJ_CMD: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ************************************************************
	// Period timers
	// ************************************************************
	logic tx_fclk;
	logic tx_start;
	logic tx_late;
	logic tx_end;
	logic rx_fclk;
	logic rx_start;
	logic rx_late;
	logic rx_end;

	cpa_period u_tx (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(mclk_tick),
		.cfg(tx_cfg_q),
		.adj_mode(tx_adj_q),
		.filter_clk(tx_fclk),
		.conv_start(tx_start),
		.late(tx_late),
		.period_end(tx_end)
	);

	cpa_period u_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(mclk_tick),
		.cfg(rx_cfg_q),
		.adj_mode(rx_adj_q),
		.filter_clk(rx_fclk),
		.conv_start(rx_start),
		.late(rx_late),
		.period_end(rx_end)
	);

	// ************************************************************
	// Transmit side configuration
	// ************************************************************
	logic byte0;
	logic wr_tx;
	logic [DIV_B_W-1:0] new_b;

	assign byte0 = wr_fire & w_strb_q[0];
	assign new_b = w_data_q[DIV_B_W-1:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_cfg_q <= '{RST_DIV_A, RST_OFFSET, RST_DIV_B};
			control_q <= RST_CONTROL;
		end else if (byte0 || (wr_fire && w_strb_q[1])) begin
			if (byte0 && aw_addr_q == OFF_TX_DIV_A)
				tx_cfg_q.div_a <= w_data_q[DIV_A_W-1:0];
			if (byte0 && aw_addr_q == OFF_TX_OFFSET)
				tx_cfg_q.offset <= w_data_q[OFFSET_W-1:0];
			if (byte0 && aw_addr_q == OFF_TX_DIV_B)
				tx_cfg_q.div_b <= (new_b <= DIV_B_W'(1)) ? DIV_B_FORCED : new_b;
			if (aw_addr_q == OFF_CONTROL) begin
				if (w_strb_q[0])
					control_q[7:0] <= w_data_q[7:0] & CTRL_MASK[7:0];
				if (w_strb_q[1])
					control_q[9:8] <= w_data_q[9:8] & CTRL_MASK[9:8];
			end
		end
	end

	// ************************************************************
	// Adjust command scheduling
	// ************************************************************
	logic adj_wr;
	logic [1:0] adj_val;

	assign adj_wr = byte0 & (aw_addr_q == OFF_ADJ_CMD);
	assign adj_val = w_data_q[1:0];
	assign wr_tx = adj_wr & (adj_val == ADJ_ADD || adj_val == ADJ_SUB);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			tx_adj_q <= ADJ_NONE;
		else if (wr_tx)
			tx_adj_q <= adj_val;
		else if (tx_end)
			tx_adj_q <= ADJ_NONE;
	end

	// Receive slots: current period, or the one after it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_adj_q <= ADJ_NONE;
			rx_adj_next_q <= ADJ_NONE;
		end else begin
			if (rx_end) begin
				rx_adj_q <= rx_adj_next_q;
				rx_adj_next_q <= ADJ_NONE;
			end
			if (wr_tx && rx_adj_q == ADJ_NONE && !rx_end) begin
				if (!rx_late)
					rx_adj_q <= adj_val;
				else if (rx_adj_next_q == ADJ_NONE)
					rx_adj_next_q <= adj_val;
			end else if (wr_tx && rx_end && rx_adj_next_q == ADJ_NONE) begin
				rx_adj_q <= adj_val;
			end
		end
	end

	// ************************************************************
	// Receive side configuration
	// ************************************************************
	logic wr_rx;
	logic [5:0] wa;

	assign wa = aw_addr_q;
	assign wr_rx = byte0 & (wa == OFF_RX_DIV_A || wa == OFF_RX_OFFSET ||
		wa == OFF_RX_DIV_B);

	// Receive values: now, staged for next, or ignored while locked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_cfg_q <= '{RST_DIV_A, RST_OFFSET, RST_DIV_B};
			rx_stage_q <= '{RST_DIV_A, RST_OFFSET, RST_DIV_B};
			rx_lock_q <= 1'b0;
			rx_staged_q <= 1'b0;
		end else begin
			if (rx_end) begin
				rx_lock_q <= rx_staged_q;
				rx_staged_q <= 1'b0;
				if (rx_staged_q)
					rx_cfg_q <= rx_stage_q;
			end
			if (wr_rx && !(rx_end ? rx_staged_q : rx_lock_q)) begin
				if (!rx_late) begin
					rx_lock_q <= 1'b1;
					if (wa == OFF_RX_DIV_A)
						rx_cfg_q.div_a <= w_data_q[DIV_A_W-1:0];
					if (wa == OFF_RX_OFFSET)
						rx_cfg_q.offset <= w_data_q[OFFSET_W-1:0];
					if (wa == OFF_RX_DIV_B)
						rx_cfg_q.div_b <= (new_b <= DIV_B_W'(1)) ?
							DIV_B_FORCED : new_b;
				end else if (!rx_staged_q) begin
					rx_staged_q <= 1'b1;
					rx_stage_q <= rx_cfg_q;
					if (wa == OFF_RX_DIV_A)
						rx_stage_q.div_a <= w_data_q[DIV_A_W-1:0];
					if (wa == OFF_RX_OFFSET)
						rx_stage_q.offset <= w_data_q[OFFSET_W-1:0];
					if (wa == OFF_RX_DIV_B)
						rx_stage_q.div_b <= (new_b <= DIV_B_W'(1)) ?
							DIV_B_FORCED : new_b;
				end
			end
		end
	end

	// ************************************************************
	// Test mode selection and pin muxing
	// ************************************************************
	cpa_test_mode_e mode;

	always_comb begin
		if (pins_sync[2])
			mode = TM_DA_PATH;
		else if (pins_sync[1])
			mode = TM_AD_PATH;
		else
			mode = TM_NORMAL;
	end

	// Registered test outputs; normal mode passes word-done signals
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_filter_clk_q <= 1'b0;
			test_pin_tx_q <= 1'b0;
			test_pin_rx_q <= 1'b0;
			rx_filter_out_en_q <= 1'b0;
			byte_mode_q <= 1'b0;
			lpf_input_test_q <= 1'b0;
		end else begin
			test_pin_tx_q <= tx_word_done;
			test_pin_rx_q <= rx_word_done;
			rx_filter_out_en_q <= 1'b0;
			test_filter_clk_q <= 1'b0;
			case (mode)
				TM_DA_PATH: begin
					test_filter_clk_q <= tx_fclk;
					test_pin_rx_q <= tx_start;
				end
				TM_AD_PATH: begin
					test_filter_clk_q <= rx_fclk;
					test_pin_tx_q <= rx_start;
					rx_filter_out_en_q <= 1'b1;
				end
				default: begin
				end
			endcase
			byte_mode_q <= (mode != TM_NORMAL) & pins_sync[0];
			lpf_input_test_q <= pins_sync[0];
		end
	end

	// Conversion starts straight from the timers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_conv_start_q <= 1'b0;
			rx_conv_start_q <= 1'b0;
		end else begin
			tx_conv_start_q <= tx_start;
			rx_conv_start_q <= rx_start;
		end
	end

	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************
	logic [31:0] rd_word;
	logic rd_hit;

	// Read mux; unused bits read as zero
	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			OFF_TX_DIV_A: rd_word = 32'(tx_cfg_q.div_a);
			OFF_TX_OFFSET: rd_word = 32'(tx_cfg_q.offset);
			OFF_TX_DIV_B: rd_word = 32'(tx_cfg_q.div_b);
			OFF_RX_DIV_A: rd_word = 32'(rx_cfg_q.div_a);
			OFF_RX_OFFSET: rd_word = 32'(rx_cfg_q.offset);
			OFF_RX_DIV_B: rd_word = 32'(rx_cfg_q.div_b);
			OFF_CONTROL: rd_word = 32'(control_q);
			OFF_ADJ_CMD: rd_word = 32'(tx_adj_q);
			OFF_STATUS: begin
				rd_word[ST_TX_PEND] = (tx_adj_q != ADJ_NONE);
				rd_word[ST_RX_PEND] = (rx_adj_q != ADJ_NONE);
				rd_word[ST_RX_NEXT] = (rx_adj_next_q != ADJ_NONE);
				rd_word[ST_RX_LOCK] = rx_lock_q;
				rd_word[ST_RX_STAGED] = rx_staged_q;
				rd_word[ST_TEST_DA] = (mode == TM_DA_PATH);
				rd_word[ST_TEST_AD] = (mode == TM_AD_PATH);
				rd_word[ST_BYTE_MODE] = byte_mode_q;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// One read at a time; answer the cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // cpa_adjust_ctrl
`default_nettype wire

//--- hdl/cpa_pkg.sv
// Package: register map, reset values, field layouts and carrier types
`default_nettype none
package cpa_pkg;
	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [5:0] OFF_TX_DIV_A = 6'h00;
	localparam logic [5:0] OFF_TX_OFFSET = 6'h04;
	localparam logic [5:0] OFF_TX_DIV_B = 6'h08;
	localparam logic [5:0] OFF_RX_DIV_A = 6'h0c;
	localparam logic [5:0] OFF_RX_OFFSET = 6'h10;
	localparam logic [5:0] OFF_RX_DIV_B = 6'h14;
	localparam logic [5:0] OFF_CONTROL = 6'h18;
	localparam logic [5:0] OFF_ADJ_CMD = 6'h1c;
	localparam logic [5:0] OFF_STATUS = 6'h20;

	// ************************************************************
	// Field widths and reset values
	// ************************************************************
	localparam int DIV_A_W = 6;
	localparam int OFFSET_W = 7;
	localparam int DIV_B_W = 7;
	localparam int CTRL_W = 10;
	localparam logic [DIV_A_W-1:0] RST_DIV_A = 6'h09;
	localparam logic [OFFSET_W-1:0] RST_OFFSET = 7'h01;
	localparam logic [DIV_B_W-1:0] RST_DIV_B = 7'h24;
	localparam logic [DIV_B_W-1:0] DIV_B_FORCED = 7'h24;
	// Control: sinx/x, gain, gain, sync, aux, loopback, highpass
	localparam logic [CTRL_W-1:0] RST_CONTROL = 10'h2e4;
	localparam logic [CTRL_W-1:0] CTRL_MASK = 10'h2fc;
	// Modulo-64 wrap for negative counter A sums
	localparam logic [7:0] CNT_A_WRAP = 8'h40;

	// Adjust command field, bits [1:0]
	localparam logic [1:0] ADJ_NONE = 2'b00;
	localparam logic [1:0] ADJ_ADD = 2'b01;
	localparam logic [1:0] ADJ_SUB = 2'b10;

	// Status field positions
	localparam int ST_TX_PEND = 0;
	localparam int ST_RX_PEND = 1;
	localparam int ST_RX_NEXT = 2;
	localparam int ST_RX_LOCK = 3;
	localparam int ST_RX_STAGED = 4;
	localparam int ST_TEST_DA = 5;
	localparam int ST_TEST_AD = 6;
	localparam int ST_BYTE_MODE = 7;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic [DIV_A_W-1:0] div_a;
		logic [OFFSET_W-1:0] offset;
		logic [DIV_B_W-1:0] div_b;
	} cpa_period_cfg_s;

	typedef enum logic [1:0] {
		TM_NORMAL,
		TM_DA_PATH,
		TM_AD_PATH
	} cpa_test_mode_e;
endpackage
`default_nettype wire

//--- hdl/cpa_sync.sv
// Three-stage synchroniser for pins from outside the clock domain
`default_nettype none
module cpa_sync import cpa_pkg::*; #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] level_q;

	// Stage chain; the first stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts once stages two and three agree
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				level_q[i] <= 1'b0;
			end else if (s2_q[i] == s3_q[i]) begin
				level_q[i] <= s3_q[i];
			end
		end
	end

	assign level = level_q;
endmodule // cpa_sync
`default_nettype wire

//--- hdl/cpa_period.sv
// Conversion period timer: counter A then counter B, with late adjust
`default_nettype none
module cpa_period import cpa_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire cpa_period_cfg_s cfg,
	input wire logic [1:0] adj_mode,
	output logic filter_clk,
	output logic conv_start,
	output logic late,
	output logic period_end
);
	logic [7:0] cnt_a_q;
	logic [DIV_B_W-1:0] cnt_b_q;
	logic fclk_q;
	logic start_q;
	logic signed [8:0] sum;
	logic [7:0] adj_load;
	logic [7:0] load_a;

	// Adjusted counter A value with modulo-64 and tiny-result guards
	always_comb begin
		sum = 9'(signed'({1'b0, cfg.div_a})) + 9'(signed'(cfg.offset));
		if (adj_mode == ADJ_SUB)
			sum = 9'(signed'({1'b0, cfg.div_a})) - 9'(signed'(cfg.offset));
		if (sum == 9'sd0 || sum == 9'sd1)
			adj_load = 8'(cfg.div_a);
		else if (sum < 0)
			adj_load = 8'(sum) + CNT_A_WRAP;
		else
			adj_load = 8'(sum);
		if (cnt_b_q == DIV_B_W'(2) && adj_mode != ADJ_NONE)
			load_a = adj_load;
		else
			load_a = 8'(cfg.div_a);
	end

	// Counters advance only on master clock edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_a_q <= 8'(RST_DIV_A);
			cnt_b_q <= RST_DIV_B;
			fclk_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (tick) begin
				if (cnt_a_q <= 8'd1) begin
					cnt_a_q <= load_a;
					fclk_q <= ~fclk_q;
					if (cnt_b_q <= DIV_B_W'(1)) begin
						cnt_b_q <= cfg.div_b;
						start_q <= 1'b1;
					end else begin
						cnt_b_q <= cnt_b_q - DIV_B_W'(1);
					end
				end else begin
					cnt_a_q <= cnt_a_q - 8'd1;
				end
			end
		end
	end

	assign filter_clk = fclk_q;
	assign conv_start = start_q;
	assign period_end = start_q;
	// From the counter A run whose end chooses the adjusted load onward
	assign late = (cnt_b_q <= DIV_B_W'(2));
endmodule // cpa_period
`default_nettype wire

//--- verification/cpa_host_model.sv
// Far-side model: free-running master clock and word-done strobes
`default_nettype none
module cpa_host_model (
	input wire logic aclk,
	output logic master_clock_in = 1'b0,
	output logic tx_word_done = 1'b0,
	output logic rx_word_done = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Stimulus
	// ************************************************************
	logic [3:0] cnt_q = 4'h0;
	// Master clock runs free; 3 ns skew keeps it off the aclk edges
	// scaled clock
	initial begin
		#3;
		forever #32 master_clock_in = ~master_clock_in;
	end
	// Strobes at two rates so a swapped path shows up
	always @(posedge aclk) begin
		cnt_q <= cnt_q + 4'h1;
		tx_word_done <= cnt_q[1];
		rx_word_done <= cnt_q[3] ^ cnt_q[0];
	end
endmodule // cpa_host_model
`default_nettype wire

//--- verification/cpa_adjust_ctrl_props.sv
// Port checker for the conversion period adjust control
`default_nettype none
module cpa_adjust_ctrl_props import cpa_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic factory_test_select_hi,
	input wire logic factory_test_select_gnd,
	input wire logic word_byte_select_neg,
	input wire logic tx_word_done,
	input wire logic rx_word_done,
	input wire logic test_filter_clk_q,
	input wire logic test_pin_tx_q,
	input wire logic test_pin_rx_q,
	input wire logic rx_filter_out_en_q,
	input wire logic lpf_input_test_q,
	input wire logic byte_mode_q,
	input wire logic tx_conv_start_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Pin levels need four cycles to pass the synchroniser and one more to reach the outputs
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
	endproperty
	a_rhold: assert property (p_rhold) else $error("rvalid dropped");
	property p_arblk;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_arblk: assert property (p_arblk) else $error("arready early");
	property p_awblk;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_awblk: assert property (p_awblk) else $error("awready early");
	property p_pulse;
		tx_conv_start_q |=> !tx_conv_start_q;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long start");
	property p_norm;
		(!factory_test_select_hi && !factory_test_select_gnd)[*7] |->
			!rx_filter_out_en_q && !byte_mode_q && !test_filter_clk_q;
	endproperty
	a_norm: assert property (p_norm) else $error("test out");
	property p_txd;
		(!factory_test_select_gnd)[*7] |->
			test_pin_tx_q == $past(tx_word_done);
	endproperty
	a_txd: assert property (p_txd) else $error("tx done lost");
	property p_rxd;
		(!factory_test_select_hi)[*7] |->
			test_pin_rx_q == $past(rx_word_done);
	endproperty
	a_rxd: assert property (p_rxd) else $error("rx done lost");
	property p_ad;
		(factory_test_select_gnd && !factory_test_select_hi)[*7] |->
			rx_filter_out_en_q;
	endproperty
	a_ad: assert property (p_ad) else $error("no filter out");
	property p_byte;
		(word_byte_select_neg &&
			(factory_test_select_hi || factory_test_select_gnd))[*7] |->
			byte_mode_q && lpf_input_test_q;
	endproperty
	a_byte: assert property (p_byte) else $error("no byte");
	property p_word;
		(!word_byte_select_neg)[*7] |-> !byte_mode_q;
	endproperty
	a_word: assert property (p_word) else $error("byte mode");
	c_pulse: cover property (tx_conv_start_q);
	c_byte: cover property (byte_mode_q);
	c_ad: cover property (rx_filter_out_en_q);
endmodule // cpa_adjust_ctrl_props
bind cpa_adjust_ctrl cpa_adjust_ctrl_props u_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.factory_test_select_hi(factory_test_select_hi),
	.factory_test_select_gnd(factory_test_select_gnd),
	.word_byte_select_neg(word_byte_select_neg),
	.tx_word_done(tx_word_done),
	.rx_word_done(rx_word_done),
	.test_filter_clk_q(test_filter_clk_q),
	.test_pin_tx_q(test_pin_tx_q),
	.test_pin_rx_q(test_pin_rx_q),
	.rx_filter_out_en_q(rx_filter_out_en_q),
	.lpf_input_test_q(lpf_input_test_q),
	.byte_mode_q(byte_mode_q),
	.tx_conv_start_q(tx_conv_start_q)
);
`default_nettype wire

//--- verification/test_conversion_period_adjust_control.sv
// Bench for the conversion period adjust control block
`default_nettype none
module test_conversion_period_adjust_control import cpa_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [5:0] awaddr = '0;
	logic [5:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic hi = 1'b0;
	logic gnd = 1'b0;
	logic wbs = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic mclk, txd, rxd, tfc, tpt, tpr, rfe, lpf, bm, txs, rxs;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	int last_t = 0;
	int last_len = 0;
	int rx_n = 0;
	cpa_adjust_ctrl DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.master_clock_in(mclk), .factory_test_select_hi(hi),
		.factory_test_select_gnd(gnd), .word_byte_select_neg(wbs),
		.tx_word_done(txd), .rx_word_done(rxd), .test_filter_clk_q(tfc),
		.test_pin_tx_q(tpt), .test_pin_rx_q(tpr),
		.rx_filter_out_en_q(rfe), .lpf_input_test_q(lpf),
		.byte_mode_q(bm), .tx_conv_start_q(txs), .rx_conv_start_q(rxs));
	cpa_host_model u_host (.aclk(aclk), .master_clock_in(mclk),
		.tx_word_done(txd), .rx_word_done(rxd));
	always #4 aclk = ~aclk;
	// Length of the last transmit period in aclk cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (txs === 1'b1) begin
			last_len <= cyc - last_t;
			last_t <= cyc;
		end
		if (rxs === 1'b1)
			rx_n <= rx_n + 1;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (!ta && awready === 1'b1) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (!tw && wready === 1'b1) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic waitp;
		do @(posedge aclk); while (txs !== 1'b1);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs;
		logic [5:0] a[7] = '{OFF_TX_DIV_A, OFF_TX_OFFSET, OFF_TX_DIV_B,
			OFF_RX_DIV_A, OFF_RX_OFFSET, OFF_RX_DIV_B, OFF_CONTROL};
		logic [31:0] e[7] = '{32'(RST_DIV_A), 32'(RST_OFFSET),
			32'(RST_DIV_B), 32'(RST_DIV_A), 32'(RST_OFFSET),
			32'(RST_DIV_B), 32'(RST_CONTROL)};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 7; i++) begin
			rd(a[i], d, r);
			chk(d, e[i]);
		end
		// Unmapped read and read-only write are refused
		rd(6'h24, d, r);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR});
		wr(OFF_STATUS, 32'h000000ff, r);
		chk(32'(r), 32'(RESP_SLVERR));
	endtask
	task automatic t_wr;
		logic [5:0] a[5] = '{OFF_TX_DIV_B, OFF_TX_DIV_B, OFF_RX_DIV_B,
			OFF_CONTROL, OFF_CONTROL};
		logic [31:0] w[5] = '{32'h1, 32'h0, 32'h1, 32'h3ff, 32'h2e4};
		logic [31:0] e[5] = '{32'h24, 32'h24, 32'h24, 32'h2fc, 32'h2e4};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 5; i++) begin
			wr(a[i], w[i], r);
			rd(a[i], d, r);
			chk(d, e[i]); // Stored value
		end
	endtask
	task automatic t_test;
		logic [2:0] p[5] = '{3'b000, 3'b100, 3'b010, 3'b011, 3'b101};
		logic [2:0] e[5] = '{3'b000, 3'b000, 3'b100, 3'b111, 3'b011};
		logic [2:0] s[5] = '{3'b000, 3'b001, 3'b010, 3'b110, 3'b101};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 5; i++) begin
			{hi, gnd, wbs} <= p[i];
			repeat (12) @(posedge aclk);
			chk(32'({rfe, bm, lpf}), 32'(e[i])); // Pins
			rd(OFF_STATUS, d, r);
			chk(32'(d[7:5]), 32'(s[i])); // Mode flags
		end
		{hi, gnd, wbs} <= 3'b000;
	endtask
	// Period delta in ticks of eight aclk cycles each
	task automatic t_adj;
		logic [6:0] o[5] = '{7'h03, 7'h03, 7'h77, 7'h74, 7'h09};
		logic [1:0] m[5] = '{ADJ_NONE, ADJ_ADD, ADJ_ADD, ADJ_ADD, ADJ_SUB};
		int e[5] = '{0, 3, 0, 52, 0};
		int base;
		logic [1:0] r;
		wr(OFF_TX_DIV_A, 32'h0a, r);
		wr(OFF_TX_DIV_B, 32'h04, r);
		for (int i = 0; i < 5; i++) begin
			wr(OFF_TX_OFFSET, 32'(o[i]), r);
			waitp();
			waitp();
			waitp();
			base = last_len;
			wr(OFF_ADJ_CMD, 32'(m[i]), r);
			waitp();
			@(posedge aclk);
			chk(32'(last_len - base), 32'(e[i] * 8)); // Delta
			waitp();
			@(posedge aclk);
			chk(32'(last_len), 32'(base));
		end
		chk(32'(rx_n != 0), 32'h1);
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_wr();
		t_test();
		t_adj();
		final_report();
	end
	// Hang guard, well beyond the expected run
	initial begin
		#300000;
		n_fail++;
		final_report();
	end
endmodule // test_conversion_period_adjust_control
`default_nettype wire
